/* verilog/flat_panel_pkg.sv */
package flat_panel_pkg;
    typedef logic [11:0] pos_t;
    // Register byte offsets
    localparam logic [7:0] OFS_PANEL = 8'h0c;
    localparam logic [7:0] OFS_HTOTAL = 8'h20;
    localparam logic [7:0] OFS_HWIDTH = 8'h24;
    localparam logic [7:0] OFS_HSTART = 8'h28;
    localparam logic [7:0] OFS_LINE = 8'h2c;
    localparam logic [7:0] OFS_VTOTAL = 8'h30;
    localparam logic [7:0] OFS_VHEIGHT = 8'h34;
    localparam logic [7:0] OFS_VSTART = 8'h38;
    localparam logic [7:0] OFS_FRAME = 8'h3c;
    localparam logic [7:0] OFS_CTRL = 8'h40;
    localparam logic [7:0] OFS_STATUS = 8'h44;
    // Field positions
    localparam int POLARITY_BIT = 23;
    localparam int WIDTH_LSB = 16;
    localparam int CTRL_SAVE_BIT = 0;
    localparam int CTRL_FMT8_BIT = 1;
    localparam int GROUP_SHIFT = 3;
    localparam int STATUS_VCOUNT_LSB = 16;
    // Field values and offsets
    localparam logic [1:0] PANEL_PASSIVE = 2'h0;
    localparam pos_t HSTART_PASSIVE_ADD = 12'h016;
    localparam pos_t HSTART_TFT_ADD = 12'h005;
    localparam pos_t ONE = 12'h001;
    // Reset values
    localparam logic RESET_POWER_SAVE = 1'b1;
    localparam logic RESET_FMT8 = 1'b0;
    // Shift clock half period, as the position bit that flips at it
    localparam int FMT4_HALF_BIT = 1;
    localparam int FMT8_HALF_BIT = 2;
endpackage

/* verilog/edge_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module edge_sync (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic async_in,
    output logic rise
);
    logic meta;
    logic stable;
    logic stable_d;

    // Two-flop synchroniser, then edge detect on the second flop only
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta <= 1'b0;
            stable <= 1'b0;
            stable_d <= 1'b0;
            rise <= 1'b0;
        end else begin
            meta <= async_in;
            stable <= meta;
            stable_d <= stable;
            rise <= stable & ~stable_d;
        end
    end
endmodule
`default_nettype wire

/* verilog/shift_formatter.sv */
`timescale 1ns/1ps
`default_nettype none
module shift_formatter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic step,
    input wire logic active,
    input wire logic [2:0] pos,
    input wire logic format8,
    input wire logic blank,
    input wire logic [7:0] pixel_word,
    output logic shift_clock,
    output logic [7:0] pixel_data_bus,
    output logic pixel_take
);
    logic group_start;
    logic shift_level;

    // Shift clock starts high on each group, falls half a period later
    always_comb begin
        group_start = (pos[1:0] == 2'h0);
        shift_level = ~pos[flat_panel_pkg::FMT4_HALF_BIT];
        if (format8) begin
            group_start = (pos == 3'h0);
            shift_level = ~pos[flat_panel_pkg::FMT8_HALF_BIT];
        end
    end

    // Data and shift clock, updated once per pixel step
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            shift_clock <= 1'b0;
            pixel_data_bus <= 8'h00;
            pixel_take <= 1'b0;
        end else begin
            pixel_take <= 1'b0;
            if (blank) begin
                shift_clock <= 1'b0;
                pixel_data_bus <= 8'h00;
            end else if (step) begin
                // rise at group start, fall after half period
                shift_clock <= active & shift_level;
                if (active && group_start) begin
                    pixel_take <= 1'b1;
                    pixel_data_bus <= format8 ? pixel_word : {pixel_word[3:0], 4'h0};
                end
            end
        end
    end
endmodule
`default_nettype wire

/* verilog/flat_panel_timing_generator.sv */
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module flat_panel_timing_generator (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pixel_clock_in,
    input wire logic [7:0] pixel_word,
    output logic pixel_take,
    output logic line_pulse,
    output logic frame_pulse,
    output logic shift_clock,
    output logic [7:0] pixel_data_bus,
    output logic polarity_alternation
);
    typedef flat_panel_pkg::pos_t pos_t;

    logic pix_tick;
    logic step;
    logic [1:0] panel_type;
    logic [5:0] alt_count_cfg;
    logic [6:0] ht_field;
    logic [6:0] hw_field;
    logic [9:0] hs_field;
    logic [9:0] lps_field;
    logic [6:0] lpw_field;
    logic line_pol;
    logic [9:0] vt_field;
    logic [9:0] vh_field;
    logic [9:0] vs_field;
    logic [9:0] fps_field;
    logic [2:0] fpw_field;
    logic frame_pol;
    logic power_save;
    logic format8;
    logic [9:0] hcount;
    logic [9:0] vcount;
    logic [5:0] alt_lines;
    logic alt_state;
    logic [31:0] next_rdata;
    logic next_err;
    logic wr_en;
    logic setup;
    pos_t ht_len;
    pos_t hdp_len;
    pos_t horizontal_display_start_pos;
    pos_t hps_pos;
    pos_t hpw_len;
    pos_t vt_len;
    pos_t vdp_len;
    pos_t vpw_len;
    pos_t hpos;
    pos_t vpos;
    pos_t hoff;
    logic end_of_line;
    logic end_of_frame;
    logic line_act;
    logic frame_act;
    logic h_disp;
    logic v_disp;

    // Pixel clock pin crosses into the bus clock domain
    edge_sync u_sync (
        .clk(pclk),
        .rst_n(presetn),
        .async_in(pixel_clock_in),
        .rise(pix_tick)
    );

    // Step follows the tick, once counters hold the new pixel
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            step <= 1'b0;
        end else begin
            step <= pix_tick;
        end
    end

    // APB phases: answer with no wait state
    assign setup = psel & ~penable;
    assign wr_en = psel & penable & pwrite & pready;

    // Register writes, taken at the completing access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            panel_type <= 2'h0;
            alt_count_cfg <= 6'h00;
            ht_field <= 7'h00;
            hw_field <= 7'h00;
            hs_field <= 10'h000;
            lps_field <= 10'h000;
            lpw_field <= 7'h00;
            line_pol <= 1'b0;
            vt_field <= 10'h000;
            vh_field <= 10'h000;
            vs_field <= 10'h000;
            fps_field <= 10'h000;
            fpw_field <= 3'h0;
            frame_pol <= 1'b0;
            power_save <= flat_panel_pkg::RESET_POWER_SAVE;
            format8 <= flat_panel_pkg::RESET_FMT8;
        end else if (wr_en) begin
            unique case (paddr)
                flat_panel_pkg::OFS_PANEL: begin
                    panel_type <= pwdata[1:0];
                    alt_count_cfg <= pwdata[flat_panel_pkg::WIDTH_LSB +: 6];
                end
                flat_panel_pkg::OFS_HTOTAL: ht_field <= pwdata[6:0];
                flat_panel_pkg::OFS_HWIDTH: hw_field <= pwdata[6:0];
                flat_panel_pkg::OFS_HSTART: hs_field <= pwdata[9:0];
                flat_panel_pkg::OFS_LINE: begin
                    lps_field <= pwdata[9:0];
                    lpw_field <= pwdata[flat_panel_pkg::WIDTH_LSB +: 7];
                    line_pol <= pwdata[flat_panel_pkg::POLARITY_BIT];
                end
                flat_panel_pkg::OFS_VTOTAL: vt_field <= pwdata[9:0];
                flat_panel_pkg::OFS_VHEIGHT: vh_field <= pwdata[9:0];
                flat_panel_pkg::OFS_VSTART: vs_field <= pwdata[9:0];
                flat_panel_pkg::OFS_FRAME: begin
                    fps_field <= pwdata[9:0];
                    fpw_field <= pwdata[flat_panel_pkg::WIDTH_LSB +: 3];
                    frame_pol <= pwdata[flat_panel_pkg::POLARITY_BIT];
                end
                flat_panel_pkg::OFS_CTRL: begin
                    power_save <= pwdata[flat_panel_pkg::CTRL_SAVE_BIT];
                    format8 <= pwdata[flat_panel_pkg::CTRL_FMT8_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    // Read mux; unmapped offsets read zero with an error
    always_comb begin
        next_rdata = 32'h0000_0000;
        next_err = 1'b0;
        unique case (paddr)
            flat_panel_pkg::OFS_PANEL: begin
                next_rdata[1:0] = panel_type;
                next_rdata[flat_panel_pkg::WIDTH_LSB +: 6] = alt_count_cfg;
            end
            flat_panel_pkg::OFS_HTOTAL: next_rdata[6:0] = ht_field;
            flat_panel_pkg::OFS_HWIDTH: next_rdata[6:0] = hw_field;
            flat_panel_pkg::OFS_HSTART: next_rdata[9:0] = hs_field;
            flat_panel_pkg::OFS_LINE: begin
                next_rdata[9:0] = lps_field;
                next_rdata[flat_panel_pkg::WIDTH_LSB +: 7] = lpw_field;
                next_rdata[flat_panel_pkg::POLARITY_BIT] = line_pol;
            end
            flat_panel_pkg::OFS_VTOTAL: next_rdata[9:0] = vt_field;
            flat_panel_pkg::OFS_VHEIGHT: next_rdata[9:0] = vh_field;
            flat_panel_pkg::OFS_VSTART: next_rdata[9:0] = vs_field;
            flat_panel_pkg::OFS_FRAME: begin
                next_rdata[9:0] = fps_field;
                next_rdata[flat_panel_pkg::WIDTH_LSB +: 3] = fpw_field;
                next_rdata[flat_panel_pkg::POLARITY_BIT] = frame_pol;
            end
            flat_panel_pkg::OFS_CTRL: begin
                next_rdata[flat_panel_pkg::CTRL_SAVE_BIT] = power_save;
                next_rdata[flat_panel_pkg::CTRL_FMT8_BIT] = format8;
            end
            flat_panel_pkg::OFS_STATUS: begin
                next_rdata[9:0] = hcount;
                next_rdata[flat_panel_pkg::STATUS_VCOUNT_LSB +: 10] = vcount;
            end
            default: next_err = 1'b1;
        endcase
    end

    // Answer registered in the setup cycle, valid in the access cycle
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= setup;
            pslverr <= setup & next_err;
            if (setup) begin
                prdata <= pwrite ? 32'h0000_0000 : next_rdata;
            end
        end
    end

    // Derived lengths and positions in pixel clocks and lines
    always_comb begin
        ht_len = pos_t'((pos_t'(ht_field) + flat_panel_pkg::ONE) << flat_panel_pkg::GROUP_SHIFT);
        hdp_len = pos_t'((pos_t'(hw_field) + flat_panel_pkg::ONE) << flat_panel_pkg::GROUP_SHIFT);
        if (panel_type == flat_panel_pkg::PANEL_PASSIVE) begin
            horizontal_display_start_pos = pos_t'(hs_field) + flat_panel_pkg::HSTART_PASSIVE_ADD;
        end else begin
            horizontal_display_start_pos = pos_t'(hs_field) + flat_panel_pkg::HSTART_TFT_ADD;
        end
        hps_pos = pos_t'(lps_field) + flat_panel_pkg::ONE;
        hpw_len = pos_t'(lpw_field) + flat_panel_pkg::ONE;
        vt_len = pos_t'(vt_field) + flat_panel_pkg::ONE;
        vdp_len = pos_t'(vh_field) + flat_panel_pkg::ONE;
        vpw_len = pos_t'(fpw_field) + flat_panel_pkg::ONE;
    end

    // Window decode from the two counters
    always_comb begin
        hpos = pos_t'(hcount);
        vpos = pos_t'(vcount);
        hoff = hpos - horizontal_display_start_pos;
        end_of_line = (hpos == ht_len - flat_panel_pkg::ONE);
        end_of_frame = (vpos == vt_len - flat_panel_pkg::ONE);
        line_act = (hpos >= hps_pos) && (hpos < hps_pos + hpw_len);
        // frame start taken with no offset
        frame_act = (vpos >= pos_t'(fps_field)) && (vpos < pos_t'(fps_field) + vpw_len);
        h_disp = (hpos >= horizontal_display_start_pos) && (hpos < horizontal_display_start_pos + hdp_len);
        v_disp = (vpos >= pos_t'(vs_field)) && (vpos < pos_t'(vs_field) + vdp_len);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hcount <= 10'h000;
            vcount <= 10'h000;
        end else if (pix_tick) begin
            if (end_of_line) begin
                hcount <= 10'h000;
                vcount <= end_of_frame ? 10'h000 : vcount + 10'h001;
            end else begin
                hcount <= hcount + 10'h001;
            end
        end
    end

    // alternation per frame or every n lines
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alt_lines <= 6'h00;
            alt_state <= 1'b0;
        end else if (step && hcount == 10'h000) begin
            // change at line start, ahead of the pulse
            if (alt_count_cfg == 6'h00) begin
                alt_lines <= 6'h00;
                if (vcount == 10'h000) begin
                    alt_state <= ~alt_state;
                end
            end else if (alt_lines + 6'h01 >= alt_count_cfg) begin
                alt_lines <= 6'h00;
                alt_state <= ~alt_state;
            end else begin
                alt_lines <= alt_lines + 6'h01;
            end
        end
    end

    // Panel control outputs, held low in power save
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            line_pulse <= 1'b0;
            frame_pulse <= 1'b0;
            polarity_alternation <= 1'b0;
        end else if (power_save) begin
            line_pulse <= 1'b0;
            frame_pulse <= 1'b0;
            polarity_alternation <= 1'b0;
        end else begin
            line_pulse <= line_act ^ ~line_pol;
            frame_pulse <= frame_act ^ ~frame_pol;
            polarity_alternation <= alt_state;
        end
    end

    // Shift clock and pixel data for the display window
    shift_formatter u_fmt (
        .clk(pclk),
        .rst_n(presetn),
        .step(step),
        .active(h_disp & v_disp),
        .pos(hoff[2:0]),
        .format8(format8),
        .blank(power_save),
        .pixel_word(pixel_word),
        .shift_clock(shift_clock),
        .pixel_data_bus(pixel_data_bus),
        .pixel_take(pixel_take)
    );

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_line_end;
        pix_tick && end_of_line;
    endsequence
    property p_hwrap;
        s_line_end |=> hcount == 10'h000;
    endproperty
    a_hwrap: assert property (p_hwrap) else $error("pixel counter did not wrap");
    property p_vwrap;
        (s_line_end and end_of_frame) |=> vcount == 10'h000;
    endproperty
    a_vwrap: assert property (p_vwrap) else $error("line counter did not wrap");
    // A register write moves the windows at once; only counter steps are judged
    property p_line_rise;
        $rose(line_act) && !$past(wr_en) |-> hpos == hps_pos;
    endproperty
    a_line_rise: assert property (p_line_rise) else $error("line pulse start wrong");
    property p_line_fall;
        $fell(line_act) && hcount != 10'h000 && !$past(wr_en) |-> hpos == hps_pos + hpw_len;
    endproperty
    a_line_fall: assert property (p_line_fall) else $error("line pulse width wrong");
    property p_frame_rise;
        $rose(frame_act) && !$past(wr_en) |-> vpos == pos_t'(fps_field) && hcount == 10'h000;
    endproperty
    a_frame_rise: assert property (p_frame_rise) else $error("frame pulse start wrong");
    property p_save;
        power_save |=> !line_pulse && !frame_pulse && !polarity_alternation;
    endproperty
    a_save: assert property (p_save) else $error("outputs active in power save");
    property p_line_pol;
        !power_save |=> line_pulse == ($past(line_act) ^ ~$past(line_pol));
    endproperty
    a_line_pol: assert property (p_line_pol) else $error("line pulse polarity wrong");
    property p_alt_time;
        $changed(alt_state) |-> hcount == 10'h000 && $past(step);
    endproperty
    a_alt_time: assert property (p_alt_time) else $error("alternation changed mid line");
    property p_disp_start;
        $rose(h_disp) && !$past(wr_en) |-> hpos == horizontal_display_start_pos;
    endproperty
    a_disp_start: assert property (p_disp_start) else $error("display start wrong");
endmodule
`default_nettype wire

/* bench/lcd_panel_model.sv */
`timescale 1ns/1ps
`default_nettype none
// Panel side: samples its lines on every pixel clock rise and measures the raster
module lcd_panel_model (
    input wire logic pix,
    input wire logic lp_act,
    input wire logic fp_act,
    input wire logic line_pulse,
    input wire logic frame_pulse,
    input wire logic shift_clock,
    input wire logic polarity_alternation,
    output logic [10:0][15:0] m
);
    logic la, fa, lp, fp, sh, al;
    logic [15:0] px, lw, ln, fw, ac, sc, shh, dl;
    // Active level of each pulse follows the chosen polarity
    assign la = (line_pulse == lp_act);
    assign fa = (frame_pulse == fp_act);
    // Edge history
    always_ff @(posedge pix) begin
        lp <= la;
        fp <= fa;
        sh <= shift_clock;
        al <= polarity_alternation;
    end
    // Line period, line width, lines per frame, frame width, display lines
    always_ff @(posedge pix) begin
        if (la && !lp) begin
            m[0] <= px + 16'h1;
            px <= 16'h0;
            lw <= 16'h1;
            ln <= ln + 16'h1;
            if (fa) fw <= fw + 16'h1;
            if (sc != 16'h0) begin
                m[5] <= sc;
                dl <= dl + 16'h1;
            end
        end else begin
            px <= px + 16'h1;
            if (la) lw <= lw + 16'h1;
        end
        if (!la && lp) m[1] <= lw;
        if (fa && !fp) begin
            m[2] <= ln;
            m[3] <= fw;
            m[8] <= dl;
            ln <= 16'h0;
            fw <= 16'h0;
            dl <= 16'h0;
        end
        // Alternation toggles per frame and their place in the line
        if (fa && !fp) m[4] <= ac;
        if (fa && !fp) ac <= {15'h0, polarity_alternation != al};
        else if (polarity_alternation != al) ac <= ac + 16'h1;
        if (polarity_alternation != al) m[10] <= px + 16'h1;
        // Shift clock count, first rise position and high time
        if (la && !lp) sc <= 16'h0;
        else if (shift_clock && !sh) sc <= sc + 16'h1;
        if (shift_clock && !sh && sc == 16'h0 && dl == 16'h0) m[9] <= ln;
        if (shift_clock && !sh && sc == 16'h0) m[6] <= px + 16'h1;
        if (shift_clock && !sh) shh <= 16'h1;
        else if (shift_clock) shh <= shh + 16'h1;
        if (!shift_clock && sh) m[7] <= shh;
    end
endmodule
`default_nettype wire

/* bench/tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic pclk, presetn, psel, penable, pwrite, pix, pready, pslverr, pixel_take;
    logic line_pulse, frame_pulse, shift_clock, polarity_alternation;
    logic lp_act, fp_act, f8, dchk, err, sh_d;
    logic [7:0] paddr, pixel_word, pixel_data_bus, e;
    logic [31:0] pwdata, prdata, seed, rd;
    logic [10:0][15:0] m;
    logic [7:0] q[$];
    int fail_count, checks;
    localparam logic [7:0] OFS [10] = '{flat_panel_pkg::OFS_PANEL, flat_panel_pkg::OFS_HTOTAL,
        flat_panel_pkg::OFS_HWIDTH, flat_panel_pkg::OFS_HSTART, flat_panel_pkg::OFS_LINE,
        flat_panel_pkg::OFS_VTOTAL, flat_panel_pkg::OFS_VHEIGHT, flat_panel_pkg::OFS_VSTART,
        flat_panel_pkg::OFS_FRAME, flat_panel_pkg::OFS_CTRL};
    flat_panel_timing_generator flat_panel_timing_generator_inst (.pclk(pclk),
        .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
        .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pixel_clock_in(pix), .pixel_word(pixel_word), .pixel_take(pixel_take),
        .line_pulse(line_pulse), .frame_pulse(frame_pulse), .shift_clock(shift_clock),
        .pixel_data_bus(pixel_data_bus), .polarity_alternation(polarity_alternation));
    lcd_panel_model lcd_panel_model_inst (.pix(pix), .lp_act(lp_act), .fp_act(fp_act),
        .line_pulse(line_pulse), .frame_pulse(frame_pulse), .shift_clock(shift_clock),
        .polarity_alternation(polarity_alternation), .m(m));
    // Bus clock and free-running pixel clock of unrelated phase
    initial begin
        pclk = 1'b0;
        forever #2 pclk = ~pclk;
    end
    initial begin
        pix = 1'b0;
        #13;
        forever #40 pix = ~pix;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t reg got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic results();
        $display("checks=%0d fail_count=%0d", checks, fail_count);
        if (fail_count == 0 && checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    // One APB transfer: setup, then access held until pready
    task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        paddr <= a;
        pwrite <= w;
        pwdata <= d;
        psel <= 1'b1;
        penable <= 1'b0;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20) begin
            fail_count++;
            results();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Pixel source: new random word after each take, expected words queued
    always @(posedge pclk) begin
        if (pixel_take === 1'b1) begin
            q.push_back(pixel_word);
            pixel_word <= 8'($random(seed));
        end
    end
    // Data seen by the panel at each shift clock fall
    always @(posedge pix) begin
        sh_d <= shift_clock;
        if (dchk && sh_d === 1'b1 && shift_clock === 1'b0 && q.size() > 0) begin
            e = q.pop_front();
            chk(f8 ? pixel_data_bus : {pixel_data_bus[7:4], 4'h0},
                f8 ? e : {e[3:0], 4'h0});
        end
    end
    task automatic run_cfg(input logic [1:0] typ, input logic fmt, input logic [5:0] alt,
        input logic pol);
        logic [31:0] v[10];
        int horizontal_display_start, n;
        n = 0;
        horizontal_display_start = (typ == 2'h0) ? 22 : 5;
        v = '{{10'h0, alt, 14'h0, typ}, 32'h9, 32'h3, 32'h0, {8'h0, pol, 7'h3, 6'h0, 10'h03b},
            32'h3, 32'h1, 32'h1, {8'h0, pol, 23'h0}, {30'h0, fmt, 1'b1}};
        for (int i = 0; i < 10; i++) apb(OFS[i], 1'b1, v[i]);
        for (int i = 0; i < 10; i++) begin
            apb(OFS[i], 1'b0, 32'h0);
            chk_reg(rd, v[i]);
        end
        repeat (1700) @(posedge pclk);
        chk({20'h0, line_pulse, frame_pulse, shift_clock, polarity_alternation,
            pixel_data_bus}, 32'h0);
        lp_act = pol;
        fp_act = pol;
        f8 = fmt;
        apb(flat_panel_pkg::OFS_CTRL, 1'b1, {30'h0, fmt, 1'b0});
        repeat (4) @(posedge pclk);
        while (frame_pulse !== pol && n < 20000) begin
            n++;
            @(posedge pclk);
        end
        if (n == 20000) begin
            fail_count++;
            results();
        end
        q.delete();
        dchk = 1'b1;
        repeat (14000) @(posedge pclk);
        chk(m[0], 80);
        chk(m[1], 4);
        chk(m[2], 4);
        chk(m[3], 1);
        chk(m[4], alt == 6'h0 ? 1 : 4 / alt);
        chk(m[5], fmt ? 4 : 8);
        chk(m[6], (horizontal_display_start - 60 + 80) % 80);
        chk(m[7], fmt ? 4 : 2);
        chk(m[8], 2);
        chk(m[9], 1);
        chk({31'h0, (80 - m[10]) >= 59}, 1);
        dchk = 1'b0;
    endtask
    // Main sequence: reset values, unmapped access, three panel setups, power save
    initial begin
        seed = 32'heff0c6e0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        pixel_word = 8'h5a;
        lp_act = 1'b1;
        fp_act = 1'b1;
        f8 = 1'b0;
        dchk = 1'b0;
        fail_count = 0;
        checks = 0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 10; i++) begin
            apb(OFS[i], 1'b0, 32'h0);
            chk_reg(rd, i == 9 ? 32'h1 : 32'h0);
        end
        apb(8'h50, 1'b1, 32'hffffffff);
        apb(8'h50, 1'b0, 32'h0);
        chk_reg({rd[30:0], err}, 32'h1);
        run_cfg(2'h0, 1'b0, 6'h0, 1'b1);
        run_cfg(2'h0, 1'b1, 6'h2, 1'b0);
        run_cfg(2'h1, 1'b0, 6'h1, 1'b0);
        apb(flat_panel_pkg::OFS_CTRL, 1'b1, 32'h1);
        @(posedge pclk);
        #1;
        chk({20'h0, line_pulse, frame_pulse, shift_clock, polarity_alternation,
            pixel_data_bus}, 32'h0);
        results();
    end
endmodule
`default_nettype wire
